// [neft_map.svh]
// constants of the noise energy feature tracker: fixed-point factors,
// thresholds and reset values; values are signed Q16.16 except the plain integer counts, limits and band indices
`ifndef NEFT_MAP_SVH
`define NEFT_MAP_SVH
`define NEFT_FRAC 16
`define NEFT_ONE 32'sh0001_0000
`define NEFT_NOISE_INIT 32'sh0000_00E5
`define NEFT_LT_INIT 32'sh0000_0000
`define NEFT_K_0P9 32'sh0000_E666
`define NEFT_K_0P1 32'sh0000_199A
`define NEFT_K_0P75 32'sh0000_C000
`define NEFT_K_0P98 32'sh0000_FAE1
`define NEFT_K_0P02 32'sh0000_051F
`define NEFT_K_0P03 32'sh0000_07AE
`define NEFT_K_0P8 32'sh0000_CCCD
`define NEFT_K_0P2 32'sh0000_3333
`define NEFT_K_0P04 32'sh0000_0A3D
`define NEFT_K_0P08 32'sh0000_147B
`define NEFT_K_0P064 32'sh0000_1062
`define NEFT_K_0P999 32'sh0000_FFBE
`define NEFT_K_THIRD 32'sh0000_5555
`define NEFT_K_10LOG2 32'sh0003_0293
`define NEFT_VAR_MAX 32'sh0003_0000
`define NEFT_TWO 32'sh0002_0000
`define NEFT_THREE 32'sh0003_0000
`define NEFT_TEN 32'sh000A_0000
`define NEFT_THIRTY 32'sh001E_0000
`define NEFT_TH_VOICE_WB 32'sh0000_8531
`define NEFT_TH_VOICE_NB 32'sh0000_A666
`define NEFT_PC_UNSTABLE 8'h0C
`define NEFT_HARM_HI 8'h32
`define NEFT_HARM_MID 8'h1E
`define NEFT_HARM_LO 8'h14
`define NEFT_INI_LIMIT 8'h96
`define NEFT_INIT_FRAMES 2'h2
`define NEFT_NB_FIRST 5'h01
`define NEFT_NB_LAST 5'h10
`endif

// [neft_pkg.sv]
// types shared by the noise energy feature tracker
package neft_pkg;
	typedef logic signed [31:0] neft_q_type;
	typedef enum logic [0:0] {NEFT_IDLE, NEFT_BANDS} neft_state_type;
endpackage

// [neft_tracker.sv]
// noise energy feature tracker: per-frame band noise and energy features
// assumes all inputs are held stable from frame_strobe until frame_done
`include "neft_map.svh"
`timescale 1ns/100ps
`default_nettype none
module neft_tracker
	import neft_pkg::*;
#(
	parameter int NB = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_strobe,
	input wire logic wideband_mode,
	input wire logic noise_inactive,
	input wire logic [NB-1:0][31:0] band_energy_first,
	input wire logic [NB-1:0][31:0] band_energy_second,
	input wire logic signed [31:0] frame_energy,
	input wire logic signed [31:0] relative_energy,
	input wire logic [7:0] harmonic_count,
	input wire logic [7:0] lag_first,
	input wire logic [7:0] lag_second,
	input wire logic signed [31:0] corr_first,
	input wire logic signed [31:0] corr_second,
	input wire logic signed [31:0] corr_third,
	input wire logic signed [31:0] noise_correction,
	input wire logic [31:0] resid_energy_2,
	input wire logic [31:0] resid_energy_16,
	output logic [NB-1:0][31:0] band_noise_energy,
	output logic [NB-1:0] band_updated,
	output logic signed [31:0] total_noise_energy,
	output logic signed [31:0] smoothed_energy,
	output logic signed [31:0] upper_energy_envelope,
	output logic signed [31:0] lower_energy_envelope,
	output logic signed [31:0] long_term_min_energy,
	output logic signed [31:0] energy_variation_feature,
	output logic signed [31:0] energy_dynamics,
	output logic [7:0] pitch_stability_counter,
	output logic pitch_stable,
	output logic signed [31:0] voicing,
	output logic signed [31:0] resid_ratio_log,
	output logic signed [31:0] nonstat_log,
	output logic frame_done
);
	if (NB < 17 || NB > 32) begin : g_chk
		$error("neft_tracker: NB must lie in 17..32");
	end

	// ---------------------------------------------
	// arithmetic helpers
	// ---------------------------------------------
	function automatic neft_q_type mulk(input neft_q_type a, input neft_q_type k);
		logic signed [63:0] p;
		p = 64'(a) * 64'(k);
		return neft_q_type'(p >>> `NEFT_FRAC);
	endfunction

	// log2 by leading one plus linear fraction; cheap, error under 0.09
	function automatic neft_q_type log2q(input logic [63:0] x);
		int p;
		logic [63:0] f;
		p = 0;
		for (int i = 0; i < 64; i++) begin
			if (x[i]) begin
				p = i;
			end
		end
		f = (p >= `NEFT_FRAC) ? (x >> (p - `NEFT_FRAC)) : (x << (`NEFT_FRAC - p));
		return neft_q_type'({16'(p - `NEFT_FRAC), f[15:0]});
	endfunction

	function automatic neft_q_type maxq(input neft_q_type a, input neft_q_type b);
		return (a > b) ? a : b;
	endfunction

	function automatic neft_q_type minq(input neft_q_type a, input neft_q_type b);
		return (a < b) ? a : b;
	endfunction

	// ---------------------------------------------
	// frame sequencing
	// ---------------------------------------------
	neft_state_type st_q;
	logic [4:0] idx_q;
	logic [63:0] acc_q;
	neft_q_type lt_avg_q [NB];
	neft_q_type prev_second_q [NB];
	logic [1:0] init_cnt_q;
	logic [7:0] ini_frame_q;
	logic [7:0] lag_prev_q;
	neft_q_type et_prev_q;
	wire logic start = frame_strobe && (st_q == NEFT_IDLE);
	wire logic last = (idx_q == 5'(NB - 1));

	// strobes arriving mid-frame are ignored so each state moves once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= NEFT_IDLE;
			idx_q <= 5'h00;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (start) begin
				st_q <= NEFT_BANDS;
				idx_q <= 5'h00;
			end else if (st_q == NEFT_BANDS) begin
				idx_q <= idx_q + 5'h01;
				if (last) begin
					// park the index on band 0 so idle reads stay inside the arrays
					idx_q <= 5'h00;
					st_q <= NEFT_IDLE;
					frame_done <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------
	// band loop, one band per cycle
	// ---------------------------------------------
	neft_q_type e0, e1, np, ep, mix, cand, mb, ltp, alpha, hi, lo;
	logic down, active;
	always_comb begin
		e0 = neft_q_type'(band_energy_first[idx_q]);
		e1 = neft_q_type'(band_energy_second[idx_q]);
		np = neft_q_type'(band_noise_energy[idx_q]);
		ep = prev_second_q[idx_q];
		mix = (ep >>> 2) + mulk(e0 + (e1 >>> 1), `NEFT_K_0P75);
		cand = mulk(np, `NEFT_K_0P9) + mulk(mix, `NEFT_K_0P1);
		down = cand < np;
		active = wideband_mode || (idx_q >= `NEFT_NB_FIRST && idx_q <= `NEFT_NB_LAST);
		mb = (e0 + e1) >>> 1;
		ltp = lt_avg_q[idx_q];
		alpha = minq(mulk(maxq(relative_energy, 32'sh0), `NEFT_K_0P064) + `NEFT_K_0P75, `NEFT_K_0P999);
		hi = maxq(mb, ltp) + `NEFT_ONE;
		lo = minq(mb, ltp) + `NEFT_ONE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NB; i++) begin
				band_noise_energy[i] <= `NEFT_NOISE_INIT;
				lt_avg_q[i] <= `NEFT_LT_INIT;
				prev_second_q[i] <= 32'sh0;
			end
			band_updated <= '0;
		end else if (st_q == NEFT_BANDS) begin
			// second stage also takes bands the first stage left alone
			if (down || noise_inactive) begin
				band_noise_energy[idx_q] <= cand;
			end
			band_updated[idx_q] <= down;
			prev_second_q[idx_q] <= e1;
			if (active) begin
				lt_avg_q[idx_q] <= mb + mulk(ltp - mb, alpha);
			end
		end
	end

	// products are kept as log2 sums: no divider, ratio stays monotonic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 64'h0;
			nonstat_log <= 32'sh0;
			total_noise_energy <= 32'sh0;
		end else if (start) begin
			acc_q <= 64'h0;
			nonstat_log <= 32'sh0;
		end else if (st_q == NEFT_BANDS) begin
			acc_q <= acc_q + 64'(np);
			if (active) begin
				nonstat_log <= nonstat_log + log2q(64'(hi)) - log2q(64'(lo));
			end
			if (last) begin
				total_noise_energy <= mulk(log2q(acc_q + 64'(np)), `NEFT_K_10LOG2);
			end
		end
	end

	// ---------------------------------------------
	// frame energy features
	// ---------------------------------------------
	neft_q_type chg, sm_d, lw, gap, a_tl;
	always_comb begin
		chg = (et_prev_q > frame_energy) ? et_prev_q - frame_energy : frame_energy - et_prev_q;
		sm_d = mulk(smoothed_energy, `NEFT_K_0P8) + mulk(frame_energy, `NEFT_K_0P2);
		lw = lower_energy_envelope + `NEFT_K_0P08;
		if (harmonic_count > `NEFT_HARM_HI && ini_frame_q < `NEFT_INI_LIMIT && et_prev_q - sm_d < `NEFT_THREE) begin
			lw = lw + minq(`NEFT_TWO, mulk(et_prev_q - lw, `NEFT_K_0P1));
		end
		gap = et_prev_q - lw;
		if (gap > `NEFT_THIRTY && harmonic_count < `NEFT_HARM_LO) begin
			lw = lw + mulk(gap, `NEFT_K_0P2);
		end else if (gap > `NEFT_TEN) begin
			lw = lw + `NEFT_K_0P08;
		end
		lw = minq(lw, frame_energy);
		if ((harmonic_count > `NEFT_HARM_MID && (et_prev_q - lw > `NEFT_THIRTY || ini_frame_q < `NEFT_INI_LIMIT))
				|| (long_term_min_energy - lw > `NEFT_THIRTY)) begin
			a_tl = `NEFT_K_0P03;
		end else begin
			a_tl = `NEFT_K_0P02;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_q <= 2'h0;
			ini_frame_q <= 8'h00;
			et_prev_q <= 32'sh0;
			smoothed_energy <= 32'sh0;
			upper_energy_envelope <= 32'sh0;
			lower_energy_envelope <= 32'sh0;
			long_term_min_energy <= 32'sh0;
			energy_variation_feature <= 32'sh0;
			energy_dynamics <= 32'sh0;
		end else if (start) begin
			et_prev_q <= frame_energy;
			if (ini_frame_q != 8'hFF) begin
				ini_frame_q <= ini_frame_q + 8'h01;
			end
			if (init_cnt_q < `NEFT_INIT_FRAMES) begin
				init_cnt_q <= init_cnt_q + 2'h1;
				smoothed_energy <= frame_energy;
				upper_energy_envelope <= frame_energy;
				lower_energy_envelope <= frame_energy;
				long_term_min_energy <= frame_energy;
				energy_variation_feature <= 32'sh0;
				energy_dynamics <= 32'sh0;
			end else begin
				energy_variation_feature <= maxq(`NEFT_K_0P1, mulk(energy_variation_feature, `NEFT_K_0P98)
					+ mulk(minq(`NEFT_VAR_MAX, chg), `NEFT_K_0P02));
				smoothed_energy <= sm_d;
				upper_energy_envelope <= maxq(upper_energy_envelope - `NEFT_K_0P04, frame_energy);
				lower_energy_envelope <= lw;
				long_term_min_energy <= long_term_min_energy + mulk(lw - long_term_min_energy, a_tl);
				energy_dynamics <= mulk(energy_dynamics, `NEFT_K_0P9) + mulk(maxq(upper_energy_envelope
					- `NEFT_K_0P04, frame_energy) - lw, `NEFT_K_0P1);
			end
		end
	end

	// ---------------------------------------------
	// basic noise update parameters
	// ---------------------------------------------
	logic [7:0] pc_d;
	neft_q_type vmean;
	always_comb begin
		pc_d = ((lag_first > lag_prev_q) ? lag_first - lag_prev_q : lag_prev_q - lag_first)
			+ ((lag_second > lag_first) ? lag_second - lag_first : lag_first - lag_second);
		vmean = mulk(corr_first + corr_second + corr_third, `NEFT_K_THIRD) + noise_correction;
		if (vmean < (wideband_mode ? `NEFT_TH_VOICE_WB : `NEFT_TH_VOICE_NB)) begin
			pc_d = `NEFT_PC_UNSTABLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lag_prev_q <= 8'h00;
			pitch_stability_counter <= 8'h00;
			pitch_stable <= 1'b0;
			voicing <= 32'sh0;
			resid_ratio_log <= 32'sh0;
		end else if (start) begin
			lag_prev_q <= lag_second;
			pitch_stability_counter <= pc_d;
			pitch_stable <= pc_d < `NEFT_PC_UNSTABLE;
			voicing <= ((corr_first + corr_second) >>> 1) + noise_correction;
			resid_ratio_log <= log2q(64'(resid_energy_2)) - log2q(64'(resid_energy_16));
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic run = init_cnt_q == `NEFT_INIT_FRAMES;
	localparam int DONE_GAP = NB;
	sequence s_start;
		start;
	endsequence
	sequence s_busy;
		st_q == NEFT_BANDS;
	endsequence
	chk_frame_len: assert property (s_start |=> s_busy ##[DONE_GAP:DONE_GAP] frame_done)
		else $error("frame did not finish in time");
	chk_keep_noise: assert property (s_busy and (!down && !noise_inactive) |=> band_noise_energy[$past(idx_q)] == $past(np))
		else $error("band noise changed upward");
	chk_pc_force: assert property (start && vmean < `NEFT_TH_VOICE_WB && wideband_mode |=> pitch_stability_counter == 8'h0C)
		else $error("low voicing did not force counter");
	chk_pitch_flag: assert property (start |=> pitch_stable == ($past(pc_d) < 8'h0C))
		else $error("pitch stable flag wrong");
	chk_upper_env: assert property (start && run |=> upper_energy_envelope >= $past(frame_energy))
		else $error("upper envelope below energy");
	chk_lower_cap: assert property (start |=> lower_energy_envelope <= $past(frame_energy))
		else $error("lower envelope above energy");
	chk_var_floor: assert property (start && run |=> energy_variation_feature >= `NEFT_K_0P1)
		else $error("variation under floor");
	chk_init_load: assert property (start && !run |=> smoothed_energy == $past(frame_energy) && energy_dynamics == 32'sh0)
		else $error("init frame load wrong");
	chk_done_pulse: assert property (frame_done |=> !frame_done)
		else $error("done longer than a cycle");
endmodule
`default_nettype wire

// [neft_upstream.sv]
// upstream analysis model: band energies, frame energy, lags, correlations
// assumes the bench calls next_frame at a falling edge, once per frame
`timescale 1ns/100ps
`default_nettype none
module neft_upstream #(
	parameter int NB = 20
) (
	output logic wideband_mode,
	output logic noise_inactive,
	output logic [NB-1:0][31:0] band_energy_first,
	output logic [NB-1:0][31:0] band_energy_second,
	output logic signed [31:0] frame_energy,
	output logic signed [31:0] relative_energy,
	output logic [7:0] harmonic_count,
	output logic [7:0] lag_first,
	output logic [7:0] lag_second,
	output logic signed [31:0] corr_first,
	output logic signed [31:0] corr_second,
	output logic signed [31:0] corr_third,
	output logic signed [31:0] noise_correction,
	output logic [31:0] resid_energy_2,
	output logic [31:0] resid_energy_16
);
	// values stay put until the next call, so they are stable all frame
	task automatic next_frame();
		logic [31:0] k;
		wideband_mode = 1'($urandom % 2);
		noise_inactive = 1'($urandom % 2);
		for (int i = 0; i < NB; i++) begin
			// quiet bands pull the noise estimate down, loud ones do not
			k = ($urandom % 2) ? 32'h0064_0000 : 32'h0000_0200;
			band_energy_first[i] = $urandom % k;
			band_energy_second[i] = $urandom % k;
		end
		frame_energy = $signed($urandom % 32'h0050_0000);
		relative_energy = $signed($urandom % 32'h0008_0000) - 32'sh0002_0000;
		harmonic_count = 8'($urandom % 80);
		lag_first = 8'(40 + $urandom % 8);
		lag_second = 8'(lag_first + $urandom % 6);
		corr_first = $signed($urandom % 32'h0001_0000);
		corr_second = $signed($urandom % 32'h0001_0000);
		corr_third = $signed($urandom % 32'h0001_0000);
		noise_correction = $signed($urandom % 32'h0000_2000);
		resid_energy_2 = 32'h0000_0100 + $urandom % 32'h0010_0000;
		resid_energy_16 = 32'h0000_0100 + $urandom % 32'h0010_0000;
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
// bench for the noise energy feature tracker with a real-valued reference
// assumes the upstream model drives every analysis input of the tracker
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import neft_pkg::*;
	localparam int NB = 20;
	logic clk, rst_n, frame_strobe, wideband_mode, noise_inactive, pitch_stable, frame_done;
	logic [NB-1:0][31:0] band_energy_first, band_energy_second, band_noise_energy;
	logic [NB-1:0] band_updated;
	logic [7:0] harmonic_count, lag_first, lag_second, pitch_stability_counter;
	logic [31:0] resid_energy_2, resid_energy_16;
	neft_q_type frame_energy, relative_energy, corr_first, corr_second, corr_third;
	neft_q_type noise_correction, total_noise_energy, smoothed_energy, upper_energy_envelope;
	neft_q_type lower_energy_envelope, long_term_min_energy, energy_variation_feature;
	neft_q_type energy_dynamics, voicing, resid_ratio_log, nonstat_log;
	int bad_count, check_count, frames, lag_prev;
	real bn[NB], e2p[NB], lta[NB], etp, sm, up, var_f, lw, lt, dyn;
	bit upd[NB], skip[NB];

	neft_upstream up_u (.*);
	neft_tracker dut_u (.*);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// compare helpers
	// ----------------------------------------
	function automatic real q(input logic [31:0] v);
		return $itor($signed(v)) / 65536.0;
	endfunction

	task automatic cq(input logic [31:0] g, input real e, input real tol);
		check_count++;
		if ((^g === 1'bx) || (q(g) - e > tol) || (e - q(g) > tol)) begin
			bad_count++;
			$display("BAD %0t value %f expected %f", $time, q(g), e);
		end
	endtask

	task automatic cb(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// reset and frame scenarios
	// ----------------------------------------
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		frames = 0;
		lag_prev = 0;
		etp = 0.0;
		foreach (bn[i]) begin
			bn[i] = 229.0 / 65536.0;
			e2p[i] = 0.0;
			lta[i] = 0.0;
			cb(band_noise_energy[i], 32'h0000_00E5);
		end
	endtask

	// extra raises a second strobe mid-frame, which must be ignored
	task automatic run_frame(input bit extra);
		real e, c, s, t, thr, mc, mb, al, atl, ns, hi, lo;
		int d, n, na;
		up_u.next_frame();
		frame_strobe = 1'b1;
		frames++;
		e = q(frame_energy);
		thr = wideband_mode ? 0.52 : 0.65;
		mc = (q(corr_first) + q(corr_second) + q(corr_third)) / 3.0 + q(noise_correction);
		d = (lag_first > lag_prev ? lag_first - lag_prev : lag_prev - lag_first);
		d += lag_second - lag_first;
		if (mc < thr) d = 12;
		lag_prev = lag_second;
		s = 0.0;
		ns = 0.0;
		na = 0;
		al = q(relative_energy) > 0.0 ? 0.064 * q(relative_energy) + 0.75 : 0.75;
		if (al > 0.999) al = 0.999;
		foreach (bn[i]) begin
			s += bn[i];
			c = 0.25 * e2p[i] + 0.75 * (q(band_energy_first[i]) + 0.5 * q(band_energy_second[i]));
			c = 0.9 * bn[i] + 0.1 * c;
			upd[i] = c < bn[i];
			skip[i] = (c - bn[i]) ** 2 < 1.0e-4;
			if (upd[i] || noise_inactive) bn[i] = c;
			e2p[i] = q(band_energy_second[i]);
			mb = (q(band_energy_first[i]) + q(band_energy_second[i])) / 2.0;
			if (wideband_mode || (i >= 1 && i <= 16)) begin
				hi = (mb > lta[i] ? mb : lta[i]) + 1.0;
				lo = (mb > lta[i] ? lta[i] : mb) + 1.0;
				ns += $ln(hi / lo) / $ln(2.0);
				na++;
				lta[i] = al * lta[i] + (1.0 - al) * mb;
			end
		end
		@(negedge clk);
		frame_strobe = 1'b0;
		if ((mc - thr) ** 2 > 2.5e-5) begin
			cb(pitch_stability_counter, 32'(d));
			cb(pitch_stable, d < 12);
		end
		cq(voicing, (q(corr_first) + q(corr_second)) / 2.0 + q(noise_correction), 0.001);
		cq(resid_ratio_log, $ln(q(resid_energy_2) / q(resid_energy_16)) / $ln(2.0), 0.1);
		if (frames <= 2) begin
			sm = e;
			up = e;
			var_f = 0.0;
			lw = e;
			lt = e;
			dyn = 0.0;
			cq(lower_energy_envelope, e, 0.0);
			cq(long_term_min_energy, e, 0.0);
			cq(energy_dynamics, 0.0, 0.0);
		end else begin
			t = etp > e ? etp - e : e - etp;
			if (t > 3.0) t = 3.0;
			var_f = 0.98 * var_f + 0.02 * t;
			if (var_f < 0.1) var_f = 0.1;
			sm = 0.8 * sm + 0.2 * e;
			up = (up - 0.04 > e) ? up - 0.04 : e;
			lw = lw + 0.08;
			if (harmonic_count > 50 && frames - 1 < 150 && etp - sm < 3.0) begin
				lw = lw + ((0.1 * (etp - lw) < 2.0) ? 0.1 * (etp - lw) : 2.0);
			end
			t = etp - lw;
			if (t > 30.0 && harmonic_count < 20) begin
				lw = lw + 0.2 * t;
			end else if (t > 10.0) begin
				lw = lw + 0.08;
			end
			if (lw > e) lw = e;
			atl = ((harmonic_count > 30 && (etp - lw > 30.0 || frames - 1 < 150)) || lt - lw > 30.0) ? 0.03 : 0.02;
			lt = lt + atl * (lw - lt);
			dyn = 0.9 * dyn + 0.1 * (up - lw);
			cq(lower_energy_envelope, lw, 0.02);
			cq(long_term_min_energy, lt, 0.02);
			cq(energy_dynamics, dyn, 0.02);
			cb(lower_energy_envelope <= frame_energy, 32'h0000_0001);
		end
		cq(energy_variation_feature, var_f, 0.01);
		cq(smoothed_energy, sm, 0.01);
		cq(upper_energy_envelope, up, 0.01);
		etp = e;
		n = 1;
		while (frame_done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
			if (n inside {5, 6}) frame_strobe = extra && n == 5;
		end
		cb(32'(n), 32'h0000_0015);
		cq(total_noise_energy, 10.0 * $log10(s), 0.3);
		cb(nonstat_log >= 0, 32'h0000_0001);
		cq(nonstat_log, ns, 0.01 + 0.09 * na);
		foreach (bn[i]) begin
			cq(band_noise_energy[i], bn[i], 0.002 + bn[i] * 0.002);
			if (!skip[i]) cb(band_updated[i], upd[i]);
		end
	endtask

	initial begin
		void'($urandom(32'hE076ADFE));
		frame_strobe = 1'b0;
		up_u.next_frame();
		do_reset();
		for (int f = 0; f < 12; f++) run_frame(f % 3 == 1);
		do_reset();
		for (int f = 0; f < 5; f++) run_frame(1'b0);
		finish_test();
	end

	// seventeen frames of some 21 cycles and two resets stay far below this
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
